// File: logic/pcep_pkg.sv
package pcep_pkg;
	// Bit positions use the port-control word's own numbering: bit 0 is the MSB.
	localparam int PCEP_W          = 32;
	localparam int PCEP_BIT_CRCOFF = 11;
	localparam int PCEP_BIT_MCAST  = 12;
	localparam int PCEP_BIT_ENUM   = 14;
	localparam int PCEP_BIT_STOP   = 28;
	localparam int PCEP_BIT_DROP   = 29;
	localparam int PCEP_BIT_LOCK   = 30;
	localparam int PCEP_BIT_PTYPE  = 31;
	localparam int PCEP_BIT_ERRDET = 0;
	localparam logic PCEP_RST_CRCOFF = 1'b0;
	localparam logic PCEP_RST_MCAST  = 1'b0;
	localparam logic PCEP_RST_STOP   = 1'b0;
	localparam logic PCEP_RST_DROP   = 1'b0;
	localparam logic PCEP_RST_LOCK   = 1'b0;
	localparam logic PCEP_PTYPE_SER  = 1'b1;
	localparam int   PCEP_ENUM_PORT  = 2;
	localparam logic [31:0] PCEP_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		PCEP_OUT_SEND,
		PCEP_OUT_DROP_REFUSED,
		PCEP_OUT_HOLD,
		PCEP_OUT_DISCARD_ALL
	} pcep_out_e;

	// Map a documented bit index (0 = MSB) onto a [31:0] vector index.
	function automatic int pcep_idx(input int b);
		return PCEP_W - 1 - b;
	endfunction
endpackage

// File: logic/pcep_policy.sv
`timescale 1ns/1ps
module pcep_policy (
	input  wire logic           stop_en,
	input  wire logic           drop_en,
	input  wire logic           output_failed,
	input  wire logic           failure_threshold_hit,
	output pcep_pkg::pcep_out_e mode
);
	import pcep_pkg::*;

	always_comb begin
		unique case ({stop_en, drop_en})
			2'b00: mode = PCEP_OUT_SEND;
			2'b01: mode = failure_threshold_hit ? PCEP_OUT_DROP_REFUSED : PCEP_OUT_SEND;
			2'b10: mode = output_failed ? PCEP_OUT_HOLD : PCEP_OUT_SEND;
			2'b11: mode = output_failed ? PCEP_OUT_DISCARD_ALL : PCEP_OUT_SEND;
		endcase
	end
endmodule // pcep_policy

// File: logic/pcep_gate.sv
`timescale 1ns/1ps
module pcep_gate (
	input  wire logic lockout,
	input  wire logic output_en,
	input  wire logic input_en,
	input  wire logic pkt_is_maint,
	output logic      may_issue,
	output logic      may_accept_rx,
	output logic      maint_only_rx
);
	always_comb begin
		may_issue     = !lockout && output_en;
		may_accept_rx = !lockout && (input_en || pkt_is_maint);
		maint_only_rx = !lockout && !input_en;
	end
endmodule // pcep_gate

// File: logic/pcep_port_control.sv
`timescale 1ns/1ps
module pcep_port_control #(
	parameter int PORT_NUM = 0
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        port_powered,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr_corrupt,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	input  wire logic        boot_load,
	input  wire logic [31:0] boot_data,
	input  wire logic        output_en,
	input  wire logic        input_en,
	input  wire logic        rx_pkt_valid,
	input  wire logic        rx_pkt_crc_bad,
	input  wire logic        rx_pkt_is_maint,
	output logic             rx_pkt_accept,
	output logic             rx_pkt_not_accepted,
	output logic             crc_check_off,
	output logic             retransmit_allowed,
	input  wire logic        rx_link_request,
	output logic             link_request_answer,
	input  wire logic        tx_link_request_want,
	output logic             tx_link_request_go,
	input  wire logic        mcast_symbol_in,
	output logic             mcast_symbol_out,
	input  wire logic        internal_switch_fabric_valid,
	output logic             internal_switch_fabric_ready,
	output logic             fabric_pkt_discard,
	output logic             queue_flush,
	output logic             tx_send_enable,
	input  wire logic        tx_not_accepted,
	output logic             tx_pkt_drop,
	output logic             pkt_dropped_flag,
	input  wire logic        pkt_dropped_clear,
	input  wire logic        output_failed,
	input  wire logic        failure_threshold_hit,
	input  wire logic        bus_error,
	input  wire logic        transport_error,
	input  wire logic        err_detect_clear,
	output logic             err_detect_bit0
);
	import pcep_pkg::*;

	localparam logic ENUM_RST = (PORT_NUM == PCEP_ENUM_PORT) ? 1'b1 : 1'b0;

	logic        crc_off_reg;
	logic        crc_off_next;
	logic        mcast_reg;
	logic        mcast_next;
	logic        enum_reg;
	logic        enum_next;
	logic        stop_reg;
	logic        stop_next;
	logic        drop_reg;
	logic        drop_next;
	logic        lock_reg;
	logic        lock_next;
	logic        lock_prev_reg;
	logic        flush_next;
	logic        powered_prev_reg;
	logic        dropped_reg;
	logic        dropped_next;
	logic        errdet_reg;
	logic        errdet_next;
	logic        port_rst;
	logic        wr_ok;
	logic        may_issue;
	logic        may_accept_rx;
	logic        maint_only_rx;
	logic [31:0] rdata_next;
	pcep_out_e   out_mode;

	// Shared update of every writable field
	function automatic logic field_next(
		input logic        cur,
		input logic        rst_val,
		input int          b,
		input logic        boot,
		input logic [31:0] boot_word,
		input logic        prst,
		input logic        wr,
		input logic [31:0] wr_word
	);
		logic nxt;
		nxt = cur;
		if (boot) begin
			nxt = boot_word[pcep_idx(b)];
		end else if (prst) begin
			nxt = rst_val;
		end else if (wr) begin
			nxt = wr_word[pcep_idx(b)];
		end
		return nxt;
	endfunction

	// Set wins over clear, so an event in the clearing cycle is not lost
	function automatic logic sticky_next(
		input logic cur,
		input logic set_in,
		input logic clr_in
	);
		logic nxt;
		nxt = cur;
		if (set_in) begin
			nxt = 1'b1;
		end else if (clr_in) begin
			nxt = 1'b0;
		end
		return nxt;
	endfunction

	// Readable word; reserved bits always read zero
	function automatic logic [31:0] pack_word(
		input logic crc_off,
		input logic mcast,
		input logic enum_b,
		input logic stop,
		input logic drop,
		input logic lock
	);
		logic [31:0] w;
		w = PCEP_ZERO;
		w[pcep_idx(PCEP_BIT_CRCOFF)] = crc_off;
		w[pcep_idx(PCEP_BIT_MCAST)]  = mcast;
		w[pcep_idx(PCEP_BIT_ENUM)]   = enum_b;
		w[pcep_idx(PCEP_BIT_STOP)]   = stop;
		w[pcep_idx(PCEP_BIT_DROP)]   = drop;
		w[pcep_idx(PCEP_BIT_LOCK)]   = lock;
		w[pcep_idx(PCEP_BIT_PTYPE)]  = PCEP_PTYPE_SER;
		return w;
	endfunction

	// Power off or a rising power edge is the port reset; resets high so leaving reset is no edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			powered_prev_reg <= 1'b1;
		end else begin
			powered_prev_reg <= port_powered;
		end
	end

	assign port_rst = !port_powered || (port_powered && !powered_prev_reg);
	// Corrupt writes dropped regardless of checking mode
	assign wr_ok = reg_wr && !reg_wr_corrupt && port_powered;

	// Boot load beats port reset, which beats a write
	assign crc_off_next = field_next(crc_off_reg, PCEP_RST_CRCOFF, PCEP_BIT_CRCOFF,
		boot_load, boot_data, port_rst, wr_ok, reg_wdata);
	assign mcast_next   = field_next(mcast_reg, PCEP_RST_MCAST, PCEP_BIT_MCAST,
		boot_load, boot_data, port_rst, wr_ok, reg_wdata);
	assign enum_next    = field_next(enum_reg, ENUM_RST, PCEP_BIT_ENUM,
		boot_load, boot_data, port_rst, wr_ok, reg_wdata);
	assign stop_next    = field_next(stop_reg, PCEP_RST_STOP, PCEP_BIT_STOP,
		boot_load, boot_data, port_rst, wr_ok, reg_wdata);
	assign drop_next    = field_next(drop_reg, PCEP_RST_DROP, PCEP_BIT_DROP,
		boot_load, boot_data, port_rst, wr_ok, reg_wdata);
	assign lock_next    = field_next(lock_reg, PCEP_RST_LOCK, PCEP_BIT_LOCK,
		boot_load, boot_data, port_rst, wr_ok, reg_wdata);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			crc_off_reg <= PCEP_RST_CRCOFF;
		end else begin
			crc_off_reg <= crc_off_next;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mcast_reg <= PCEP_RST_MCAST;
		end else begin
			mcast_reg <= mcast_next;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			enum_reg <= ENUM_RST;
		end else begin
			enum_reg <= enum_next;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stop_reg <= PCEP_RST_STOP;
		end else begin
			stop_reg <= stop_next;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			drop_reg <= PCEP_RST_DROP;
		end else begin
			drop_reg <= drop_next;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lock_reg <= PCEP_RST_LOCK;
		end else begin
			lock_reg <= lock_next;
		end
	end

	// Read data registered; an unpowered port reads as zero
	assign rdata_next = port_powered ? pack_word(crc_off_reg, mcast_reg, enum_reg,
		stop_reg, drop_reg, lock_reg) : PCEP_ZERO;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= PCEP_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end
	end

	pcep_gate u_gate (
		.lockout       (lock_reg),
		.output_en     (output_en),
		.input_en      (input_en),
		.pkt_is_maint  (rx_pkt_is_maint),
		.may_issue     (may_issue),
		.may_accept_rx (may_accept_rx),
		.maint_only_rx (maint_only_rx)
	);

	pcep_policy u_policy (
		.stop_en               (stop_reg),
		.drop_en               (drop_reg),
		.output_failed         (output_failed),
		.failure_threshold_hit (failure_threshold_hit),
		.mode                  (out_mode)
	);

	assign crc_check_off      = crc_off_reg;
	assign retransmit_allowed = !crc_off_reg;

	// Bad CRC is only tolerated when checking is off
	always_comb begin
		rx_pkt_accept       = 1'b0;
		rx_pkt_not_accepted = 1'b0;
		if (rx_pkt_valid) begin
			if (lock_reg) begin
				rx_pkt_not_accepted = 1'b1;
			end else if (rx_pkt_crc_bad && !crc_off_reg) begin
				rx_pkt_not_accepted = 1'b1;
			end else if (may_accept_rx) begin
				rx_pkt_accept = 1'b1;
			end else begin
				rx_pkt_not_accepted = maint_only_rx;
			end
		end
	end

	// Link maintenance is outside the lockout gate
	assign link_request_answer = rx_link_request;
	assign tx_link_request_go  = tx_link_request_want;

	assign mcast_symbol_out = mcast_symbol_in && mcast_reg;

	// Fabric always drained while locked so nothing backs up
	assign internal_switch_fabric_ready = lock_reg || may_issue;
	assign fabric_pkt_discard = lock_reg && internal_switch_fabric_valid;

	// One-cycle flush on the rising edge of lockout
	assign flush_next = lock_reg && !lock_prev_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lock_prev_reg <= 1'b0;
		end else begin
			lock_prev_reg <= lock_reg;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			queue_flush <= 1'b0;
		end else begin
			queue_flush <= flush_next;
		end
	end

	always_comb begin
		tx_send_enable = 1'b0;
		tx_pkt_drop    = 1'b0;
		if (may_issue) begin
			unique case (out_mode)
				PCEP_OUT_SEND: tx_send_enable = 1'b1;
				PCEP_OUT_DROP_REFUSED: begin
					tx_send_enable = 1'b1;
					tx_pkt_drop    = tx_not_accepted;
				end
				PCEP_OUT_HOLD: tx_send_enable = 1'b0;
				PCEP_OUT_DISCARD_ALL: tx_pkt_drop = internal_switch_fabric_valid;
			endcase
		end
	end

	assign dropped_next = sticky_next(dropped_reg, tx_pkt_drop, pkt_dropped_clear || port_rst);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dropped_reg <= 1'b0;
		end else begin
			dropped_reg <= dropped_next;
		end
	end
	assign pkt_dropped_flag = dropped_reg;

	assign errdet_next = sticky_next(errdet_reg, port_powered && (bus_error || transport_error),
		err_detect_clear || port_rst);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			errdet_reg <= 1'b0;
		end else begin
			errdet_reg <= errdet_next;
		end
	end
	assign err_detect_bit0 = errdet_reg;
endmodule // pcep_port_control

// File: bench/pcep_monitor.sv
`timescale 1ns/1ps
module pcep_monitor (
	input wire logic	clock,
	input wire logic	reset_n,
	input wire logic	port_powered,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic	reg_wr_corrupt,
	input wire logic [31:0]	reg_wdata,
	input wire logic [31:0]	reg_rdata,
	input wire logic	boot_load,
	input wire logic [31:0]	boot_data,
	input wire logic	rx_pkt_valid,
	input wire logic	rx_pkt_accept,
	input wire logic	rx_pkt_not_accepted,
	input wire logic	mcast_symbol_in,
	input wire logic	mcast_symbol_out,
	input wire logic	internal_switch_fabric_valid,
	input wire logic	fabric_pkt_discard,
	input wire logic	queue_flush,
	input wire logic	tx_send_enable,
	input wire logic	tx_pkt_drop,
	input wire logic	pkt_dropped_flag,
	input wire logic	output_failed,
	input wire logic	output_en,
	input wire logic	transport_error,
	input wire logic	bus_error,
	input wire logic	err_detect_bit0
);
	logic [31:0]	sh_reg;
	logic		pw_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Own copy of the control word, so no assertion trusts the read path
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sh_reg <= 32'h0;
			pw_reg <= 1'b1;
		end else begin
			pw_reg <= port_powered;
			if (boot_load) sh_reg <= boot_data;
			else if (!port_powered || !pw_reg) sh_reg <= 32'h0;
			else if (reg_wr && !reg_wr_corrupt) sh_reg <= reg_wdata;
		end
	end
	sequence s_dropped;
		tx_pkt_drop ##1 pkt_dropped_flag;
	endsequence
	a_lock_rx_refused: assert property (rx_pkt_valid && sh_reg[1] |->
		rx_pkt_not_accepted && !rx_pkt_accept) else $error("locked port took a packet");
	a_lock_fabric_drop: assert property (internal_switch_fabric_valid && sh_reg[1] |->
		fabric_pkt_discard) else $error("locked port kept a fabric packet");
	a_lock_flush_pulse: assert property ($rose(sh_reg[1]) |-> ##[0:1] queue_flush)
		else $error("no queue flush after lockout");
	a_mcast_gate: assert property (mcast_symbol_out == (mcast_symbol_in && sh_reg[19]))
		else $error("multicast symbol gating wrong");
	a_unpowered_reads_zero: assert property (reg_rd && !port_powered |=> reg_rdata == 32'h0)
		else $error("unpowered read not zero");
	a_err_flag_set: assert property ((bus_error || transport_error) && port_powered |=>
		err_detect_bit0) else $error("error detect flag not set");
	a_stop_halts_send: assert property (sh_reg[3] && !sh_reg[2] && output_failed |->
		!tx_send_enable) else $error("stop mode still sending");
	a_drop_all_mode: assert property (sh_reg[3] && sh_reg[2] && !sh_reg[1] && output_failed
		&& output_en && internal_switch_fabric_valid |-> s_dropped) else $error("drop-all did not drop");
endmodule // pcep_monitor

bind pcep_port_control pcep_monitor i_pcep_monitor (.*);

// File: bench/pcep_link_partner.sv
`timescale 1ns/1ps
module pcep_link_partner (
	input wire logic	clock,
	input wire logic	rx_pkt_accept,
	input wire logic	rx_pkt_not_accepted,
	input wire logic	link_request_answer,
	input wire logic	mcast_symbol_out,
	input wire logic	tx_pkt_drop,
	output logic		rx_pkt_valid,
	output logic		rx_pkt_crc_bad,
	output logic		rx_pkt_is_maint,
	output logic		rx_link_request,
	output logic		mcast_symbol_in,
	output logic		tx_not_accepted
);
	logic [5:0]	lines = 6'h0;
	assign {rx_pkt_valid, rx_pkt_crc_bad, rx_pkt_is_maint} = lines[5:3];
	assign {rx_link_request, mcast_symbol_in, tx_not_accepted} = lines[2:0];
	task automatic drv(input logic [5:0] v, output logic [4:0] r);
		@(negedge clock);
		lines = v;
		// Read the settled answer ahead of the edge that registers it
		#10;
		r = {rx_pkt_accept, rx_pkt_not_accepted, link_request_answer, mcast_symbol_out, tx_pkt_drop};
		@(posedge clock);
		@(negedge clock);
		// Qualifiers flip on release so a stale value never looks valid
		lines = {1'b0, ~v[4:3], 3'h0};
	endtask
endmodule // pcep_link_partner

// File: bench/pcep_port_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module pcep_port_control_tb_top;
	logic clock, reset_n, port_powered, reg_wr, reg_rd, reg_wr_corrupt, boot_load;
	logic output_en, input_en, rx_pkt_valid, rx_pkt_crc_bad, rx_pkt_is_maint, rx_pkt_accept;
	logic rx_pkt_not_accepted, crc_check_off, retransmit_allowed, rx_link_request;
	logic link_request_answer, tx_link_request_want, tx_link_request_go, mcast_symbol_in;
	logic mcast_symbol_out, internal_switch_fabric_valid, internal_switch_fabric_ready;
	logic fabric_pkt_discard, queue_flush, tx_send_enable, tx_not_accepted, tx_pkt_drop;
	logic pkt_dropped_flag, pkt_dropped_clear, output_failed, failure_threshold_hit;
	logic bus_error, transport_error, err_detect_clear, err_detect_bit0;
	logic [31:0]	reg_wdata, reg_rdata, boot_data;
	logic [4:0]	r;
	int		n_mismatch, tests_run;

	pcep_port_control #(.PORT_NUM(2)) i_pcep_port_control (.*);
	pcep_link_partner i_pcep_link_partner (.*);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [31:0] d, input logic c);
		@(negedge clock);
		{reg_wr, reg_wr_corrupt, reg_wdata} = {1'b1, c, d};
		@(negedge clock);
		{reg_wr, reg_wr_corrupt, reg_wdata} = {2'h0, ~d};
	endtask
	task automatic rd(input logic [31:0] e);
		@(negedge clock);
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		`CHK("rdata", reg_rdata, e)
	endtask
	task automatic pulse(ref logic s);
		@(negedge clock);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask
	initial begin
		{port_powered, output_en, input_en, tx_link_request_want} = 4'hf;
		{reset_n, reg_wr, reg_rd, reg_wr_corrupt, boot_load, bus_error} = 6'h0;
		{internal_switch_fabric_valid, pkt_dropped_clear, output_failed} = 3'h0;
		{failure_threshold_hit, transport_error, err_detect_clear} = 3'h0;
		{reg_wdata, boot_data} = {32'h0, 32'h0010_0000};
		repeat (20) @(negedge clock);
		reset_n = 1'b1;
		rd(32'h0002_0001);
		wr(32'h001a_000e, 1'b0);
		rd(32'h001a_000f);
		internal_switch_fabric_valid = 1'b1;
		i_pcep_link_partner.drv(6'h26, r);
		`CHK("locked rx", r[4:1], 4'h7)
		`CHK("fabric discard", fabric_pkt_discard, 1'b1)
		`CHK("locked link side", {tx_link_request_go, internal_switch_fabric_ready}, 2'h3)
		internal_switch_fabric_valid = 1'b0;
		wr(32'h0, 1'b1);
		rd(32'h001a_000f);
		wr(32'h0, 1'b0);
		i_pcep_link_partner.drv(6'h26, r);
		`CHK("open rx", r[4:1], 4'ha)
		i_pcep_link_partner.drv(6'h30, r);
		`CHK("bad crc", r[4:3], 2'h1)
		wr(32'h0010_0000, 1'b0);
		i_pcep_link_partner.drv(6'h30, r);
		`CHK("crc off", {r[4:3], retransmit_allowed, crc_check_off}, 4'h9)
		wr(32'h0, 1'b1);
		rd(32'h0010_0001);
		{output_failed, failure_threshold_hit} = 2'h3;
		for (int m = 0; m < 4; m++) begin
			wr({28'h0, m[1:0], 2'h0}, 1'b0);
			internal_switch_fabric_valid = 1'b1;
			i_pcep_link_partner.drv(6'h01, r);
			internal_switch_fabric_valid = 1'b0;
			`CHK("send", tx_send_enable, !m[1])
			`CHK("drop", {r[0], pkt_dropped_flag}, {2{m[0]}})
			pulse(pkt_dropped_clear);
		end
		{output_failed, failure_threshold_hit} = 2'h0;
		pulse(bus_error);
		`CHK("err det", err_detect_bit0, 1'b1)
		pulse(err_detect_clear);
		`CHK("err det", err_detect_bit0, 1'b0)
		pulse(transport_error);
		`CHK("err det", err_detect_bit0, 1'b1)
		wr(32'h0000_0002, 1'b0);
		port_powered = 1'b0;
		wr(32'h0008_0000, 1'b0);
		rd(32'h0);
		port_powered = 1'b1;
		rd(32'h0002_0001);
		pulse(boot_load);
		rd(32'h0010_0001);
		reset_n = 1'b0;
		@(negedge clock);
		reset_n = 1'b1;
		rd(32'h0002_0001);
		close_out;
	end
	initial begin
		repeat (3000) @(posedge clock);
		n_mismatch++;
		close_out;
	end
endmodule // pcep_port_control_tb_top
